// ==== verification/low_power_mode_controller_chk.sv ====
// Assertions on the mode controller ports
`timescale 1ns/100ps
`include "low_power_mode_controller_consts.vh"
module low_power_mode_controller_chk #(
  parameter SUBACTIVE_OPTION = 1
) (
  input wire clk,
  input wire reset,
  input wire clockEnable,
  input wire standbyInstruction,
  input wire stopInstruction,
  input wire watchSelectBit,
  input wire lowSpeedOnFlag,
  input wire interruptTaken,
  input wire [`IRQ_WIDTH-1:0] interruptFlags,
  input wire [`IRQ_WIDTH-1:0] interruptMasks,
  input wire externalInterruptZero,
  input wire timerAInterrupt,
  input wire [2:0] mode,
  input wire cpuClockEnable,
  input wire peripheralClockEnable,
  input wire timeBaseClockEnable,
  input wire systemOscillatorEnable,
  input wire subsystemClockSelect,
  input wire adcEnable,
  input wire outputsHighZ,
  input wire serialInterruptEnable,
  input wire globalInterruptEnableFlag,
  input wire haltCancelled
);
  // ==========
  // Helpers: pending must be steady past the synchroniser depth
  wire pend = |(interruptFlags & ~interruptMasks);
  wire halt = clockEnable && (standbyInstruction || stopInstruction);
  reg [1:0] pendHist;
  always @(posedge clk)
    pendHist <= {pendHist[0], pend};
  wire quiet = !pend && pendHist == 2'b00;
  wire [2:0] wakeMode = (lowSpeedOnFlag && SUBACTIVE_OPTION) ? `MODE_SUBACTIVE : `MODE_ACTIVE;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // Properties
  property p_sby_in;
    mode == `MODE_ACTIVE && clockEnable && standbyInstruction && !stopInstruction && quiet |=> mode == `MODE_STANDBY;
  endproperty
  a_sby_in: assert property (p_sby_in) else $error("standby not entered");
  property p_sby_clk;
    mode == `MODE_STANDBY |-> !cpuClockEnable && peripheralClockEnable && systemOscillatorEnable;
  endproperty
  a_sby_clk: assert property (p_sby_clk) else $error("standby gating wrong");
  property p_stop_in;
    mode == `MODE_ACTIVE && clockEnable && stopInstruction && !watchSelectBit && quiet |=> mode == `MODE_STOP;
  endproperty
  a_stop_in: assert property (p_stop_in) else $error("stop not entered");
  property p_stop_st;
    mode == `MODE_STOP |-> !cpuClockEnable && !timeBaseClockEnable && !systemOscillatorEnable && outputsHighZ;
  endproperty
  a_stop_st: assert property (p_stop_st) else $error("stop state wrong");
  property p_stop_hold;
    mode == `MODE_STOP |=> mode == `MODE_STOP;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");
  property p_watch_in;
    (mode == `MODE_ACTIVE && stopInstruction && watchSelectBit || mode == `MODE_SUBACTIVE && halt) && clockEnable
      && quiet |=> mode == `MODE_WATCH;
  endproperty
  a_watch_in: assert property (p_watch_in) else $error("watch not entered");
  property p_watch_st;
    mode == `MODE_WATCH |-> !cpuClockEnable && !peripheralClockEnable && timeBaseClockEnable && !serialInterruptEnable;
  endproperty
  a_watch_st: assert property (p_watch_st) else $error("watch state wrong");
  property p_watch_wake;
    mode == `MODE_WATCH && clockEnable && $rose(externalInterruptZero) && !timerAInterrupt
      |=> mode == `MODE_WATCH ##[1:3] mode == wakeMode;
  endproperty
  a_watch_wake: assert property (p_watch_wake) else $error("watch wake wrong");
  property p_sub_st;
    mode == `MODE_SUBACTIVE |-> cpuClockEnable && subsystemClockSelect && !systemOscillatorEnable && !adcEnable;
  endproperty
  a_sub_st: assert property (p_sub_st) else $error("subactive state wrong");
  property p_cancel;
    mode == `MODE_ACTIVE && halt && !globalInterruptEnableFlag && pend && pendHist == 2'b11
      |=> haltCancelled && mode == `MODE_ACTIVE;
  endproperty
  a_cancel: assert property (p_cancel) else $error("halt not cancelled");
  property p_ie;
    clockEnable && interruptTaken |=> !globalInterruptEnableFlag;
  endproperty
  a_ie: assert property (p_ie) else $error("enable flag not cleared");
  c_standby: cover property (mode == `MODE_STANDBY);
  c_stop: cover property (mode == `MODE_STOP);
  c_sub: cover property (mode == `MODE_SUBACTIVE);
endmodule // low_power_mode_controller_chk
bind low_power_mode_controller low_power_mode_controller_chk #(.SUBACTIVE_OPTION(SUBACTIVE_OPTION)) chk (
  .clk, .reset, .clockEnable, .standbyInstruction, .stopInstruction, .watchSelectBit, .lowSpeedOnFlag,
  .interruptTaken, .interruptFlags, .interruptMasks, .externalInterruptZero, .timerAInterrupt, .mode,
  .cpuClockEnable, .peripheralClockEnable, .timeBaseClockEnable, .systemOscillatorEnable, .subsystemClockSelect,
  .adcEnable, .outputsHighZ, .serialInterruptEnable, .globalInterruptEnableFlag, .haltCancelled);

// ==== verification/test_low_power_mode_controller.sv ====
// Self-checking bench for the mode controller
`timescale 1ns/100ps
`include "low_power_mode_controller_consts.vh"
module test_low_power_mode_controller;
  reg clk = 1'b0;
  reg standbyInstruction = 1'b0;
  reg stopInstruction = 1'b0;
  reg watchSelectBit = 1'b0;
  reg lowSpeedOnFlag = 1'b0;
  reg interruptTaken = 1'b0;
  reg returnFromInterruptInstruction = 1'b0;
  reg [6:0] interruptFlags = 7'h00;
  reg portModeBWrite = 1'b0;
  reg [3:0] portModeBData = 4'h0;
  reg fireReset = 1'b0;
  reg fireExt = 1'b0;
  reg fireTimer = 1'b0;
  wire reset, externalInterruptZero, timerAInterrupt, cpuClockEnable, peripheralClockEnable, timeBaseClockEnable;
  wire systemOscillatorEnable, subsystemClockSelect, adcEnable, outputsHighZ, serialInterruptEnable;
  wire globalInterruptEnableFlag, interruptServiceRequest, haltCancelled, registerReset, ioReset;
  wire [2:0] mode;
  wire [3:0] secondPortModeRegister;
  integer n_errors = 0;
  integer n_checks = 0;
  always #5 clk = ~clk;
  wake_source src (.clk, .fireReset, .fireExt, .fireTimer, .reset, .externalInterruptZero, .timerAInterrupt);
  low_power_mode_controller DUT (.clk, .reset, .clockEnable(1'b1), .standbyInstruction, .stopInstruction,
    .watchSelectBit, .lowSpeedOnFlag, .interruptTaken, .returnFromInterruptInstruction, .interruptFlags,
    .interruptMasks(7'h00), .externalInterruptZero, .timerAInterrupt, .serialInterruptIn(1'b0), .portModeBWrite,
    .portModeBData, .mode, .cpuClockEnable, .peripheralClockEnable, .timeBaseClockEnable, .systemOscillatorEnable,
    .subsystemClockSelect, .adcEnable, .registerReset, .ioReset, .outputsHighZ, .serialInterruptEnable,
    .globalInterruptEnableFlag, .secondPortModeRegister, .interruptServiceRequest, .haltCancelled);
  task chk_mode(input [2:0] got, input [2:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t mode %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_val(input [3:0] got, input [3:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for a wake-up; a hang shows as a mode mismatch
  task wait_mode(input [2:0] exp);
    integer i;
    begin
      for (i = 0; i < 12 && mode !== exp; i = i + 1)
        @(posedge clk) #1;
      chk_mode(mode, exp);
    end
  endtask
  task ins(input s, input t);
    begin
      @(posedge clk);
      standbyInstruction <= s;
      stopInstruction <= t;
      @(posedge clk);
      standbyInstruction <= 1'b0;
      stopInstruction <= 1'b0;
      #1;
    end
  endtask
  task t_standby;
    begin
      @(posedge clk) returnFromInterruptInstruction <= 1'b1;
      @(posedge clk) returnFromInterruptInstruction <= 1'b0;
      #1 chk_val(globalInterruptEnableFlag, 4'h1);
      ins(1'b1, 1'b0);
      chk_mode(mode, `MODE_STANDBY);
      chk_val({cpuClockEnable, peripheralClockEnable, systemOscillatorEnable}, 4'h3);
      @(posedge clk) interruptFlags <= 7'h01;
      wait_mode(`MODE_ACTIVE);
      @(posedge clk) #1 chk_val(interruptServiceRequest, 4'h1);
      @(posedge clk) interruptTaken <= 1'b1;
      @(posedge clk) interruptTaken <= 1'b0;
      #1 chk_val(globalInterruptEnableFlag, 4'h0);
      ins(1'b0, 1'b1);
      chk_val(haltCancelled, 4'h1);
      chk_mode(mode, `MODE_ACTIVE);
      @(posedge clk) interruptFlags <= 7'h00;
      repeat (4) @(posedge clk);
    end
  endtask
  task t_stop;
    begin
      @(posedge clk);
      portModeBWrite <= 1'b1;
      portModeBData <= 4'hA;
      @(posedge clk) portModeBWrite <= 1'b0;
      ins(1'b0, 1'b1);
      chk_mode(mode, `MODE_STOP);
      chk_val({outputsHighZ, systemOscillatorEnable, cpuClockEnable}, 4'h4);
      chk_val({registerReset, ioReset}, 4'h3);
      ins(1'b1, 1'b0);
      chk_mode(mode, `MODE_STOP);
      @(posedge clk) fireReset <= 1'b1;
      @(posedge clk) fireReset <= 1'b0;
      repeat (12) @(posedge clk);
      #1 chk_mode(mode, `MODE_ACTIVE);
      chk_val(secondPortModeRegister, 4'hA);
    end
  endtask
  task t_watch;
    begin
      @(posedge clk) watchSelectBit <= 1'b1;
      ins(1'b0, 1'b1);
      chk_mode(mode, `MODE_WATCH);
      chk_val({cpuClockEnable, peripheralClockEnable, timeBaseClockEnable, serialInterruptEnable}, 4'h2);
      @(posedge clk) fireExt <= 1'b1;
      @(posedge clk) fireExt <= 1'b0;
      wait_mode(`MODE_ACTIVE);
      repeat (6) @(posedge clk) lowSpeedOnFlag <= 1'b1;
      ins(1'b0, 1'b1);
      @(posedge clk) fireTimer <= 1'b1;
      @(posedge clk) fireTimer <= 1'b0;
      wait_mode(`MODE_SUBACTIVE);
      chk_val({subsystemClockSelect, systemOscillatorEnable, adcEnable, cpuClockEnable}, 4'h9);
      repeat (6) @(posedge clk) lowSpeedOnFlag <= 1'b0;
      ins(1'b1, 1'b0);
      chk_mode(mode, `MODE_WATCH);
      @(posedge clk) fireExt <= 1'b1;
      @(posedge clk) fireExt <= 1'b0;
      wait_mode(`MODE_ACTIVE);
    end
  endtask
  task complete_run;
    begin
      $display("Checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 chk_mode(mode, `MODE_ACTIVE);
    t_standby;
    t_stop;
    t_watch;
    complete_run;
  end
  // Whole run is under a hundred cycles; this only catches a hang
  initial begin
    #100000;
    n_errors = n_errors + 1;
    complete_run;
  end
endmodule // test_low_power_mode_controller

// ==== verification/wake_source.sv ====
// Reset and wake-up request sources facing the mode controller
`timescale 1ns/100ps
module wake_source #(
  parameter STAB_CYCLES = 8
) (
  input wire clk,
  input wire fireReset,
  input wire fireExt,
  input wire fireTimer,
  output wire reset,
  output wire externalInterruptZero,
  output wire timerAInterrupt
);
  localparam [4:0] STAB = STAB_CYCLES;
  reg [4:0] count = 5'h06;
  reg [3:0] extHold = 4'h0;
  reg [3:0] timerHold = 4'h0;
  // Held a full settling span so a stopped oscillator can restart
  assign reset = count != 5'h00;
  // Requests outlast the two-flop synchroniser so none is lost
  assign externalInterruptZero = |extHold;
  assign timerAInterrupt = |timerHold;
  always @(posedge clk) begin
    if (fireReset)
      count <= STAB;
    else if (count != 5'h00)
      count <= count - 5'h01;
    extHold <= {extHold[2:0], fireExt};
    timerHold <= {timerHold[2:0], fireTimer};
  end
endmodule // wake_source

// ==== verilog/low_power_mode_controller.v ====
// Operating-mode sequencer: active, standby, stop, watch and subactive modes
`timescale 1ns/100ps
`include "low_power_mode_controller_consts.vh"
// =====================================================================
// Notes on behaviour
// - Standby instruction in active enters standby.
// - Standby stops CPU clock, keeps peripherals running.
// - Reset or interrupt ends standby; reset resets.
// - Interrupt wake from standby resumes active.
// - Waking interrupt serviced only if enable set.
// - Stop with watch select zero enters stop.
// - Stop mode halts all clocks and oscillator.
// - RAM kept after stop; some registers undefined.
// - Stop resets registers except second port mode.
// - Stop mode resets I/O, outputs high impedance.
// - Watch from stop/select one or subactive halt.
// - Watch keeps subclock and time base only.
// - Reset, external interrupt zero, timer A end watch.
// - Subactive runs CPU from subclock, A/D idle.
// - Subactive exists only with build option.
// - Serial shifts in watch, raises no interrupts.
// - Active entered on reset release or wake.
// - Active clocks CPU and peripherals from system oscillator.
// - Enable cleared on interrupt, set by return.
// - Watch wake goes to subactive if low-speed flag.
// - Halt with pending unmasked, disabled interrupt is no-op.
module low_power_mode_controller #(
  parameter SUBACTIVE_OPTION = `SUBACTIVE_OPTION_DEFAULT
) (
  // Clock, synchronous reset and global freeze
  input wire clk,
  input wire reset,
  input wire clockEnable,

  // Instruction strobes and mode flags from the CPU, same clock
  input wire standbyInstruction,
  input wire stopInstruction,
  input wire watchSelectBit,
  input wire lowSpeedOnFlag,
  input wire interruptTaken,
  input wire returnFromInterruptInstruction,

  // Request levels; the pin sources are synchronised below
  input wire [`IRQ_WIDTH-1:0] interruptFlags,
  input wire [`IRQ_WIDTH-1:0] interruptMasks,
  input wire externalInterruptZero,
  input wire timerAInterrupt,
  input wire serialInterruptIn,

  // Write port of the second port-mode register
  input wire portModeBWrite,
  input wire [3:0] portModeBData,

  // Present mode and its clock gating
  output reg [2:0] mode,
  output reg cpuClockEnable,
  output reg peripheralClockEnable,
  output reg timeBaseClockEnable,
  output reg systemOscillatorEnable,
  output reg subsystemClockSelect,
  output reg adcEnable,

  // Reset and float controls, raised only in stop mode; serial interrupt enable, lowered in stop and watch
  output reg registerReset,
  output reg ioReset,
  output reg outputsHighZ,
  output reg serialInterruptEnable,

  // Interrupt handshake and retained register
  output reg globalInterruptEnableFlag,
  output reg [3:0] secondPortModeRegister,
  output reg interruptServiceRequest,
  output reg haltCancelled
);

  // =====================================================================
  // State codes, tied to the shared mode encoding
  // The mode port carries these codes directly, so they must not drift
  // from the shared macros that the bench decodes.
  localparam [2:0] ST_ACTIVE = `MODE_ACTIVE;
  localparam [2:0] ST_STANDBY = `MODE_STANDBY;
  localparam [2:0] ST_STOP = `MODE_STOP;
  localparam [2:0] ST_WATCH = `MODE_WATCH;
  localparam [2:0] ST_SUBACTIVE = `MODE_SUBACTIVE;

  // =====================================================================
  // Pin synchronisers for asynchronous wake sources
  // Every pin source passes two flops; only the second flop feeds logic
  reg [`IRQ_WIDTH-1:0] irqMeta;
  reg [`IRQ_WIDTH-1:0] irqSync;
  reg int0Meta;
  reg int0Sync;
  reg timerAMeta;
  reg timerASync;

  always @(posedge clk) begin
    if (reset) begin
      irqMeta <= {`IRQ_WIDTH{1'b0}};
      irqSync <= {`IRQ_WIDTH{1'b0}};
    end else if (clockEnable) begin
      irqMeta <= interruptFlags;
      irqSync <= irqMeta;
    end
  end

  // External interrupt zero may arrive from a pin at any time
  always @(posedge clk) begin
    if (reset) begin
      int0Meta <= 1'b0;
      int0Sync <= 1'b0;
    end else if (clockEnable) begin
      int0Meta <= externalInterruptZero;
      int0Sync <= int0Meta;
    end
  end

  // Timer A wakes watch mode, so it is treated as asynchronous too
  always @(posedge clk) begin
    if (reset) begin
      timerAMeta <= 1'b0;
      timerASync <= 1'b0;
    end else if (clockEnable) begin
      timerAMeta <= timerAInterrupt;
      timerASync <= timerAMeta;
    end
  end

  // =====================================================================
  // Wake and halt qualification
  wire [`IRQ_WIDTH-1:0] unmaskedPending;
  wire anyPending;
  wire subactiveAllowed;
  wire haltBlocked;
  wire watchWake;

  // A set mask bit blocks its request from waking or cancelling a halt
  genvar g;
  generate
    for (g = 0; g < `IRQ_WIDTH; g = g + 1) begin : gen_unmask
      assign unmaskedPending[g] = irqSync[g] & ~interruptMasks[g];
    end
  endgenerate

  assign anyPending = |unmaskedPending;
  assign subactiveAllowed = (SUBACTIVE_OPTION != 0);
  // Halting with a request pending and interrupts off would sleep forever
  assign haltBlocked = ~globalInterruptEnableFlag & anyPending;
  // Other requests stay pending through watch mode
  assign watchWake = int0Sync | timerASync;

  // =====================================================================
  // Mode state machine
  // Outside reset, mode and the halt-cancel pulse move only on enabled edges
  reg [2:0] next_mode;
  reg next_haltCancelled;

  always @* begin
    next_mode = mode;
    next_haltCancelled = 1'b0;
    case (mode)
      ST_ACTIVE: begin
        if ((standbyInstruction | stopInstruction) & haltBlocked) begin
          next_haltCancelled = 1'b1;
        end else if (stopInstruction) begin
          next_mode = watchSelectBit ? `MODE_WATCH : `MODE_STOP;
        end else if (standbyInstruction) begin
          next_mode = `MODE_STANDBY;
        end
      end

      ST_STANDBY: begin
        if (anyPending) begin
          next_mode = `MODE_ACTIVE;
        end
      end

      ST_STOP: begin
        // Only reset leaves stop; other triggers are ignored
        next_mode = `MODE_STOP;
      end

      ST_WATCH: begin
        if (watchWake) begin
          if (lowSpeedOnFlag & subactiveAllowed) begin
            next_mode = `MODE_SUBACTIVE;
          end else begin
            next_mode = `MODE_ACTIVE;
          end
        end
      end

      ST_SUBACTIVE: begin
        if ((standbyInstruction | stopInstruction) & haltBlocked) begin
          next_haltCancelled = 1'b1;
        end else if (standbyInstruction | stopInstruction) begin
          next_mode = `MODE_WATCH;
        end
      end

      // Unused codes fall back to active
      default: begin
        next_mode = `MODE_ACTIVE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      mode <= `MODE_RESET_VALUE;
      haltCancelled <= 1'b0;
    end else if (clockEnable) begin
      // The cancel pulse lasts one enabled cycle
      mode <= next_mode;
      haltCancelled <= next_haltCancelled;
    end
  end

  // =====================================================================
  // Clock gating and retention controls, registered from next mode
  always @(posedge clk) begin
    if (reset) begin
      cpuClockEnable <= 1'b1;
      peripheralClockEnable <= 1'b1;
      timeBaseClockEnable <= 1'b1;
      systemOscillatorEnable <= 1'b1;
      subsystemClockSelect <= 1'b0;
      adcEnable <= 1'b1;
      registerReset <= 1'b0;
      ioReset <= 1'b0;
      outputsHighZ <= 1'b0;
      serialInterruptEnable <= 1'b1;
    end else if (clockEnable) begin
      // Default all off except serial interrupt enable; the case below turns on what the mode keeps
      cpuClockEnable <= 1'b0;
      peripheralClockEnable <= 1'b0;
      timeBaseClockEnable <= 1'b0;
      systemOscillatorEnable <= 1'b0;
      subsystemClockSelect <= 1'b0;
      adcEnable <= 1'b0;
      registerReset <= 1'b0;
      ioReset <= 1'b0;
      outputsHighZ <= 1'b0;
      serialInterruptEnable <= 1'b1;

      // Registered from next mode so gating changes with the mode port
      case (next_mode)
        `MODE_ACTIVE: begin
          cpuClockEnable <= 1'b1;
          peripheralClockEnable <= 1'b1;
          timeBaseClockEnable <= 1'b1;
          systemOscillatorEnable <= 1'b1;
          adcEnable <= 1'b1;
        end

        `MODE_STANDBY: begin
          peripheralClockEnable <= 1'b1;
          timeBaseClockEnable <= 1'b1;
          systemOscillatorEnable <= 1'b1;
          adcEnable <= 1'b1;
        end

        `MODE_STOP: begin
          // All clocks off; the reset and float flags are raised and serial interrupt enable is lowered
          registerReset <= 1'b1;
          ioReset <= 1'b1;
          outputsHighZ <= 1'b1;
          serialInterruptEnable <= 1'b0;
        end

        `MODE_WATCH: begin
          timeBaseClockEnable <= 1'b1;
          subsystemClockSelect <= 1'b1;
          serialInterruptEnable <= 1'b0;
        end

        `MODE_SUBACTIVE: begin
          cpuClockEnable <= 1'b1;
          peripheralClockEnable <= 1'b1;
          timeBaseClockEnable <= 1'b1;
          subsystemClockSelect <= 1'b1;
        end

        default: begin
          cpuClockEnable <= 1'b1;
        end
      endcase
    end
  end

  // =====================================================================
  // Global interrupt enable and service request
  always @(posedge clk) begin
    if (reset) begin
      globalInterruptEnableFlag <= `IE_RESET;
    end else if (clockEnable) begin
      // Taking an interrupt wins over a simultaneous return
      if (interruptTaken | (mode == `MODE_STOP)) begin
        globalInterruptEnableFlag <= 1'b0;
      end else if (returnFromInterruptInstruction) begin
        globalInterruptEnableFlag <= 1'b1;
      end
    end
  end

  // Service is only asked for while the CPU clock runs
  always @(posedge clk) begin
    if (reset) begin
      interruptServiceRequest <= 1'b0;
    end else if (clockEnable) begin
      // Requests stay pending in the flags while enable is low
      interruptServiceRequest <= anyPending & globalInterruptEnableFlag & cpuClockEnable &
        ~interruptTaken;
    end
  end

  // =====================================================================
  // Second port-mode register survives stop mode
  // The reset that ends stop lasts many cycles, but mode is already
  // active after its first edge, so a reset that began in stop is
  // remembered until reset is released.
  reg resetFromStop;

  always @(posedge clk) begin
    if (reset) begin
      if (mode == `MODE_STOP) begin
        resetFromStop <= 1'b1;
      end
    end else begin
      resetFromStop <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset & (mode != `MODE_STOP) & ~resetFromStop) begin
      secondPortModeRegister <= `PORT_MODE_B_RESET;
    end else if (clockEnable & portModeBWrite & cpuClockEnable) begin
      secondPortModeRegister <= portModeBData;
    end
  end

  wire unusedSerial;
  assign unusedSerial = serialInterruptIn;

endmodule // low_power_mode_controller

// ==== verilog/low_power_mode_controller_consts.vh ====
// Mode encodings and option settings for the low-power mode controller
`ifndef LOW_POWER_MODE_CONTROLLER_CONSTS_VH
`define LOW_POWER_MODE_CONTROLLER_CONSTS_VH
`define MODE_ACTIVE 3'h0
`define MODE_STANDBY 3'h1
`define MODE_STOP 3'h2
`define MODE_WATCH 3'h3
`define MODE_SUBACTIVE 3'h4
`define MODE_RESET_VALUE 3'h0
`define SUBACTIVE_OPTION_DEFAULT 1'h1
`define PORT_MODE_B_RESET 4'h0
`define IE_RESET 1'h0
`define IRQ_WIDTH 7
`endif
